// File: logic/serial_port_pkg.sv
// Purpose: constants shared by the serial port design
// Assumes: processor special-function register bus, 8-bit data
// Notes:   bit positions refer to serial_port_control
package serial_port_pkg;
    localparam logic [7:0] CONTROL_ADDR   = 8'h98;
    localparam logic [7:0] BUFFER_ADDR    = 8'h99;
    localparam logic [7:0] CONTROL_RESET  = 8'h40;
    localparam int         MODE_BIT       = 7;
    localparam int         FIXED_BIT      = 6;
    localparam int         MCE_BIT        = 5;
    localparam int         REN_BIT        = 4;
    localparam int         TB8_BIT        = 3;
    localparam int         RB8_BIT        = 2;
    localparam int         TI_BIT         = 1;
    localparam int         RI_BIT         = 0;
    localparam int         OVERSAMPLE     = 16;
    localparam logic [3:0] MID_COUNT      = 4'h7;
    localparam logic [3:0] LAST_COUNT     = 4'hf;
    localparam int         DATA_BITS      = 8;
    localparam int         FIFO_DEPTH     = 8;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_DATA  = 3'b011,
        ST_NINTH = 3'b010,
        ST_STOP  = 3'b110
    } line_state_e;
endpackage : serial_port_pkg

// File: logic/serial_port.sv
// Purpose: asynchronous full-duplex serial port, 8-bit and 9-bit frames
// Assumes: baud_tick is a one-cycle pulse at 16x the bit rate, same clock
// Notes:   transmit bytes queue in a small fifo ahead of the shifter
// How it works
// - separate transmit and receive engines run concurrently
// - mode bit picks 8-bit or 9-bit frames
// - 8-bit frame: start, eight data LSB first, stop
// - writing serial_buffer starts a transmission
// - 8-bit mode: tx flag at stop start
// - 9-bit mode: tx flag at stop start
// - receiver runs only while receive enable set
// - 8-bit mode: stop bit goes to rx ninth
// - load only if rx flag clear and, with mce set, check passes
// - failed load leaves buffer, ninth bit, flag alone
// - overrun keeps first byte, later frames dropped
// - rx flag set at stop bit sample
// - interrupt request while either flag set
// - flags cleared only by software writing zero
// - 8-bit mode check demands stop bit one
// - 9-bit mode check demands ninth bit one
// - 9-bit mode sends tx ninth bit
// - 9-bit mode stores received ninth bit
// - control bit 6 reads one, ignores writes
`timescale 1ns/1ps

module serial_tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    wr_d;
    logic [AW-1:0]    rd_q;
    logic [AW-1:0]    rd_d;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             push;
    logic             pop;

    assign in_ready  = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_d    = push ? wr_q + 1'b1 : wr_q;
        rd_d    = pop ? rd_q + 1'b1 : rd_q;
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end else begin
            wr_q    <= wr_d;
            rd_q    <= rd_d;
            count_q <= count_d;
        end
    end

    // storage has no reset; out_valid guards it
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule : serial_tx_fifo

module serial_port
    import serial_port_pkg::*;
#(
    parameter int TX_DEPTH = serial_port_pkg::FIFO_DEPTH
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    output logic            tx_buffer_ready,
    input  wire logic       baud_tick,
    output logic            tx_pin,
    input  wire logic       rx_pin,
    output logic            serial_irq
);
    import serial_port_pkg::*;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    // control register fields
    logic       mode_q, mode_d;
    logic       mce_q, mce_d;
    logic       ren_q, ren_d;
    logic       tb8_q, tb8_d;
    logic       rb8_q, rb8_d;
    logic       ti_q, ti_d;
    logic       ri_q, ri_d;
    logic [7:0] rx_buf_q, rx_buf_d;
    logic [7:0] rdata_q, rdata_d;
    logic       ctl_wr;
    logic       buf_wr;
    logic [7:0] control_view;

    // transmit side
    line_state_e tx_st_q, tx_st_d;
    logic [3:0]  tx_tick_q, tx_tick_d;
    logic [2:0]  tx_bit_q, tx_bit_d;
    logic [7:0]  tx_sh_q, tx_sh_d;
    logic        tx_pin_q, tx_pin_d;
    logic        tx_set;
    logic [7:0]  fifo_data;
    logic        fifo_valid;
    logic        fifo_pop;

    // receive side
    line_state_e rx_st_q, rx_st_d;
    logic [3:0]  rx_tick_q, rx_tick_d;
    logic [2:0]  rx_bit_q, rx_bit_d;
    logic [7:0]  rx_sh_q, rx_sh_d;
    logic        rx_n9_q, rx_n9_d;
    logic        rx_meta_q, rx_sync_q;
    logic        rx_set;
    logic        rx_load;
    logic        rx_check;

    assign ctl_wr = sfr_wr && hit(sfr_addr, CONTROL_ADDR);
    assign buf_wr = sfr_wr && hit(sfr_addr, BUFFER_ADDR);

    always_comb begin
        control_view            = '0;
        control_view[MODE_BIT]  = mode_q;
        control_view[FIXED_BIT] = 1'b1;
        control_view[MCE_BIT]   = mce_q;
        control_view[REN_BIT]   = ren_q;
        control_view[TB8_BIT]   = tb8_q;
        control_view[RB8_BIT]   = rb8_q;
        control_view[TI_BIT]    = ti_q;
        control_view[RI_BIT]    = ri_q;
    end

    // byte writes to serial_buffer queue for the transmitter
    serial_tx_fifo #(
        .WIDTH (DATA_BITS),
        .DEPTH (TX_DEPTH)
    ) u_tx_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_data   (sfr_wdata),
        .in_valid  (buf_wr),
        .in_ready  (tx_buffer_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    assign fifo_pop = (tx_st_q == ST_IDLE) && fifo_valid;

    // transmit engine, one bit per sixteen ticks
    always_comb begin
        tx_st_d   = tx_st_q;
        tx_tick_d = tx_tick_q;
        tx_bit_d  = tx_bit_q;
        tx_sh_d   = tx_sh_q;
        tx_pin_d  = tx_pin_q;
        tx_set    = 1'b0;
        if (tx_st_q == ST_IDLE) begin
            tx_pin_d = 1'b1;
            if (fifo_valid) begin
                tx_sh_d   = fifo_data;
                tx_st_d   = ST_START;
                tx_tick_d = '0;
                tx_pin_d  = 1'b0;
            end
        end else if (baud_tick) begin
            tx_tick_d = tx_tick_q + 1'b1;
            if (tx_tick_q == LAST_COUNT) begin
                case (tx_st_q)
                    ST_START: begin
                        tx_st_d  = ST_DATA;
                        tx_bit_d = '0;
                        tx_pin_d = tx_sh_q[0];
                        tx_sh_d  = {1'b1, tx_sh_q[7:1]};
                    end
                    ST_DATA: begin
                        tx_bit_d = tx_bit_q + 1'b1;
                        if (tx_bit_q != 3'h7) begin
                            tx_pin_d = tx_sh_q[0];
                            tx_sh_d  = {1'b1, tx_sh_q[7:1]};
                        end else if (mode_q) begin
                            tx_st_d  = ST_NINTH;
                            tx_pin_d = tb8_q;
                        end else begin
                            tx_st_d  = ST_STOP;
                            tx_pin_d = 1'b1;
                            tx_set   = 1'b1;
                        end
                    end
                    ST_NINTH: begin
                        tx_st_d  = ST_STOP;
                        tx_pin_d = 1'b1;
                        tx_set   = 1'b1;
                    end
                    ST_STOP: begin
                        tx_st_d = ST_IDLE;
                    end
                    default: begin
                        tx_st_d = ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tx_st_q   <= ST_IDLE;
            tx_tick_q <= '0;
            tx_bit_q  <= '0;
            tx_sh_q   <= '0;
            tx_pin_q  <= 1'b1;
        end else begin
            tx_st_q   <= tx_st_d;
            tx_tick_q <= tx_tick_d;
            tx_bit_q  <= tx_bit_d;
            tx_sh_q   <= tx_sh_d;
            tx_pin_q  <= tx_pin_d;
        end
    end

    assign tx_pin = tx_pin_q;

    // rx_pin comes from outside: two stages before use
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= rx_pin;
            rx_sync_q <= rx_meta_q;
        end
    end

    // receive engine; mid-bit sampling after start qualification
    always_comb begin
        rx_st_d   = rx_st_q;
        rx_tick_d = rx_tick_q;
        rx_bit_d  = rx_bit_q;
        rx_sh_d   = rx_sh_q;
        rx_n9_d   = rx_n9_q;
        rx_set    = 1'b0;
        rx_load   = 1'b0;
        rx_check  = 1'b0;
        if (!ren_q) begin
            rx_st_d = ST_IDLE;
        end else if (rx_st_q == ST_IDLE) begin
            if (!rx_sync_q) begin
                rx_st_d   = ST_START;
                rx_tick_d = '0;
            end
        end else if (baud_tick) begin
            rx_tick_d = rx_tick_q + 1'b1;
            case (rx_st_q)
                ST_START: begin
                    if (rx_tick_q == MID_COUNT) begin
                        rx_tick_d = '0;
                        rx_bit_d  = '0;
                        rx_st_d   = rx_sync_q ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rx_tick_q == LAST_COUNT) begin
                        rx_sh_d  = {rx_sync_q, rx_sh_q[7:1]};
                        rx_bit_d = rx_bit_q + 1'b1;
                        if (rx_bit_q == 3'h7) begin
                            rx_st_d = mode_q ? ST_NINTH : ST_STOP;
                        end
                    end
                end
                ST_NINTH: begin
                    if (rx_tick_q == LAST_COUNT) begin
                        rx_n9_d = rx_sync_q;
                        rx_st_d = ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (rx_tick_q == LAST_COUNT) begin
                        rx_st_d = ST_IDLE;
                        // 8-bit mode checks stop, 9-bit checks ninth
                        rx_check = mode_q ? rx_n9_q : rx_sync_q;
                        rx_load = !ri_q && (!mce_q || rx_check);
                        rx_set  = rx_load;
                    end
                end
                default: begin
                    rx_st_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_st_q   <= ST_IDLE;
            rx_tick_q <= '0;
            rx_bit_q  <= '0;
            rx_sh_q   <= '0;
            rx_n9_q   <= 1'b0;
        end else begin
            rx_st_q   <= rx_st_d;
            rx_tick_q <= rx_tick_d;
            rx_bit_q  <= rx_bit_d;
            rx_sh_q   <= rx_sh_d;
            rx_n9_q   <= rx_n9_d;
        end
    end

    // register file; hardware set beats software clear
    always_comb begin
        mode_d   = mode_q;
        mce_d    = mce_q;
        ren_d    = ren_q;
        tb8_d    = tb8_q;
        rb8_d    = rb8_q;
        ti_d     = ti_q;
        ri_d     = ri_q;
        rx_buf_d = rx_buf_q;
        if (ctl_wr) begin
            mode_d = sfr_wdata[MODE_BIT];
            mce_d  = sfr_wdata[MCE_BIT];
            ren_d  = sfr_wdata[REN_BIT];
            tb8_d  = sfr_wdata[TB8_BIT];
            rb8_d  = sfr_wdata[RB8_BIT];
            ti_d   = sfr_wdata[TI_BIT];
            ri_d   = sfr_wdata[RI_BIT];
        end
        if (rx_load) begin
            rx_buf_d = rx_sh_q;
            rb8_d    = rx_check;
        end
        ti_d = ti_d | tx_set;
        ri_d = ri_d | rx_set;
        rdata_d = rdata_q;
        if (sfr_rd) begin
            rdata_d = hit(sfr_addr, CONTROL_ADDR) ? control_view
                    : hit(sfr_addr, BUFFER_ADDR)  ? rx_buf_q : 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mode_q   <= CONTROL_RESET[MODE_BIT];
            mce_q    <= CONTROL_RESET[MCE_BIT];
            ren_q    <= CONTROL_RESET[REN_BIT];
            tb8_q    <= CONTROL_RESET[TB8_BIT];
            rb8_q    <= CONTROL_RESET[RB8_BIT];
            ti_q     <= CONTROL_RESET[TI_BIT];
            ri_q     <= CONTROL_RESET[RI_BIT];
            rx_buf_q <= '0;
            rdata_q  <= '0;
        end else begin
            mode_q   <= mode_d;
            mce_q    <= mce_d;
            ren_q    <= ren_d;
            tb8_q    <= tb8_d;
            rb8_q    <= rb8_d;
            ti_q     <= ti_d;
            ri_q     <= ri_d;
            rx_buf_q <= rx_buf_d;
            rdata_q  <= rdata_d;
        end
    end

    assign sfr_rdata  = rdata_q;
    assign serial_irq = ti_q | ri_q;
endmodule : serial_port

// File: tb/serial_port_chk.sv
// Purpose: port-level assertions for serial_port
// Assumes: baud_tick pulses once every fourth clock
// Notes:   attached by the bind at the foot of this file
`timescale 1ns/1ps
module serial_port_chk
    import serial_port_pkg::*;
#(
    parameter int TX_DEPTH = FIFO_DEPTH
) (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic       tx_buffer_ready,
    input wire logic       baud_tick,
    input wire logic       tx_pin,
    input wire logic       rx_pin,
    input wire logic       serial_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic rd_ctl;
    logic wr_ctl;
    logic wr_buf;
    assign rd_ctl = sfr_rd && sfr_addr == CONTROL_ADDR;
    assign wr_ctl = sfr_wr && sfr_addr == CONTROL_ADDR;
    assign wr_buf = sfr_wr && sfr_addr == BUFFER_ADDR;
    a_fixed_bit_one: assert property (
        rd_ctl |=> sfr_rdata[FIXED_BIT]) else $error("control bit 6 read low");
    a_irq_flag_match: assert property (
        rd_ctl |=> (sfr_rdata[TI_BIT] || sfr_rdata[RI_BIT]) == $past(serial_irq))
        else $error("irq disagrees with flags");
    a_flag_sw_clear: assert property (
        $fell(serial_irq) |-> $past(wr_ctl)) else $error("flag cleared by hardware");
    a_idle_after_reset: assert property (
        $rose(reset_n) |-> tx_pin) else $error("tx line not idle high");
    a_ready_after_write: assert property (
        $fell(tx_buffer_ready) |-> $past(wr_buf)) else $error("fifo filled without write");
    a_tx_on_tick: assert property (
        $changed(tx_pin) |-> $past(baud_tick) || $past(baud_tick, 2) || $past(wr_buf, 2))
        else $error("tx edge off the bit clock");
    a_low_min_width: assert property (
        $fell(tx_pin) |-> !tx_pin [*8]) else $error("tx low bit too short");
    a_high_min_width: assert property (
        $rose(tx_pin) |-> tx_pin [*8]) else $error("tx high bit too short");
endmodule : serial_port_chk

bind serial_port serial_port_chk #(.TX_DEPTH(TX_DEPTH)) chk (
    .clk, .reset_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .tx_buffer_ready, .baud_tick, .tx_pin, .rx_pin, .serial_irq
);

// File: tb/serial_remote.sv
// Purpose: remote asynchronous transceiver on the serial lines
// Assumes: 16 baud ticks per bit, same ticks as the port
// Notes:   decoded frames queue in got, stop bit above the data
`timescale 1ns/1ps
module serial_remote (
    input  wire logic clk,
    input  wire logic baud_tick,
    input  wire logic tx_pin,
    input  wire logic nine_mode,
    output logic      rx_pin
);
    logic [9:0] got [$];
    logic [9:0] word;
    int         nb;
    initial rx_pin = 1'b1;

    task automatic tk(input int n);
        repeat (n) @(posedge clk iff baud_tick);
    endtask : tk

    // called just after an edge; returns just after an edge
    task automatic bit_out(input logic b, input int n);
        rx_pin = b;
        tk(n);
        #1;
    endtask : bit_out

    task automatic send(input logic [8:0] d, input int n, input logic stp);
        bit_out(1'b0, 16);
        for (int i = 0; i < n; i++) bit_out(d[i], 16);
        // low stop cut short so it cannot pass for a new start
        bit_out(stp, stp ? 16 : 11);
        bit_out(1'b1, 16);
    endtask : send

    // sample each bit mid-way, stop last
    always begin
        @(negedge tx_pin);
        nb = nine_mode ? 9 : 8;
        word = '0;
        tk(8);
        for (int i = 0; i <= nb; i++) begin
            tk(16);
            word[i] = tx_pin;
        end
        got.push_back(word);
    end
endmodule : serial_remote

// File: tb/serial_port_test.sv
// Purpose: register-level tests of serial_port against a remote model
// Assumes: baud tick every fourth clock
// Notes:   runs about 15k clocks
`timescale 1ns/1ps
module serial_port_test;
    import serial_port_pkg::*;
    logic       clk, reset_n, sfr_wr, sfr_rd, baud_tick, nine_mode;
    logic       tx_buffer_ready, tx_pin, rx_pin, serial_irq;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, r;
    logic [9:0] w;
    logic [1:0] bc = 2'd0;
    int         fail_count, n_compared, k;
    logic [7:0] tm [3] = '{8'h08, 8'h80, 8'h88};
    logic [7:0] rm [6] = '{8'h30, 8'h10, 8'hb0, 8'hb0, 8'h90, 8'h00};
    logic [8:0] rx_d [6] = '{9'h0e7, 9'h081, 9'h022, 9'h144, 9'h0c8, 9'h055};
    logic       rx_s [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [7:0] ec [6] = '{8'h70, 8'h51, 8'hf0, 8'hf5, 8'hd1, 8'h40};
    logic [7:0] eb [6] = '{8'h3c, 8'h81, 8'h81, 8'h44, 8'hc8, 8'hc8};

    serial_port #(.TX_DEPTH(8)) dut (.clk, .reset_n, .sfr_addr, .sfr_wr, .sfr_rd,
        .sfr_wdata, .sfr_rdata, .tx_buffer_ready, .baud_tick, .tx_pin, .rx_pin,
        .serial_irq);
    serial_remote far (.clk, .baud_tick, .tx_pin, .nine_mode, .rx_pin);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        #1;
        baud_tick = (bc == 2'd3);
        bc = bc + 2'd1;
    end

    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk);
        #1 sfr_wr = 1'b0;
        @(posedge clk);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk);
        #1 sfr_rd = 1'b0;
        r = sfr_rdata;
        @(posedge clk);
        #1;
    endtask : rd

    task automatic ctl(input logic [7:0] e);
        rd(CONTROL_ADDR);
        chk("control", {2'b0, e}, {2'b0, r});
    endtask : ctl

    task automatic get_frame;
        for (int i = 0; i < 3000 && far.got.size() == 0; i++) @(posedge clk);
        #1;
        chk("frame count", 10'h1, 10'(far.got.size()));
        w = far.got.size() > 0 ? far.got.pop_front() : 10'h3ff;
    endtask : get_frame

    task automatic tx_one(input logic [7:0] d, input logic [7:0] c);
        wr(BUFFER_ADDR, d);
        for (int i = 0; i < 2000 && serial_irq !== 1'b1; i++) @(posedge clk);
        #1;
        chk("pin at flag", 10'h1, {9'h0, tx_pin});
        chk("frame early", 10'h0, 10'(far.got.size()));
        get_frame();
        chk("tx frame", c[7] ? {1'b1, c[3], d} : {2'b01, d}, w);
    endtask : tx_one

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    initial begin
        #400000;
        fail_count++;
        $display("Error watchdog expected done seen timeout");
        final_report();
    end

    initial begin
        {sfr_wr, sfr_rd, nine_mode} = 3'h0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        reset_n = 1'b0;
        fail_count = 0;
        n_compared = 0;
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        ctl(8'h40);
        rd(8'h9a);
        chk("unmapped", 10'h0, {2'b0, r});
        for (k = 0; k < 3; k++) begin
            wr(CONTROL_ADDR, tm[k]);
            nine_mode = tm[k][7];
            ctl(tm[k] | 8'h40);
            tx_one(8'ha5 + 8'(k), tm[k]);
            ctl(tm[k] | 8'h42);
            wr(CONTROL_ADDR, tm[k]);
            ctl(tm[k] | 8'h40);
            chk("irq", 10'h0, {9'h0, serial_irq});
        end
        wr(CONTROL_ADDR, 8'h00);
        nine_mode = 1'b0;
        // let the last stop bit end so the shifter takes the first byte
        repeat (64) @(posedge clk);
        #1;
        for (k = 0; k < 10; k++) wr(BUFFER_ADDR, 8'h10 + 8'(k));
        chk("ready", 10'h0, {9'h0, tx_buffer_ready});
        for (k = 0; k < 9; k++) begin
            get_frame();
            chk("queued frame", 10'h110 + 10'(k), w);
        end
        repeat (800) @(posedge clk);
        #1;
        chk("dropped", 10'h0, 10'(far.got.size()));
        chk("ready", 10'h1, {9'h0, tx_buffer_ready});
        wr(CONTROL_ADDR, 8'h10);
        fork
            far.send(9'h03c, 8, 1'b1);
            wr(BUFFER_ADDR, 8'h5a);
        join
        ctl(8'h57);
        rd(BUFFER_ADDR);
        chk("rx byte", 10'h03c, {2'b0, r});
        get_frame();
        chk("duplex tx", 10'h15a, w);
        far.send(9'h0c3, 8, 1'b1);
        rd(BUFFER_ADDR);
        chk("overrun", 10'h03c, {2'b0, r});
        for (k = 0; k < 6; k++) begin
            wr(CONTROL_ADDR, rm[k]);
            nine_mode = rm[k][7];
            far.send(rx_d[k], rm[k][7] ? 9 : 8, rx_s[k]);
            ctl(ec[k]);
            rd(BUFFER_ADDR);
            chk("rx buffer", {2'b0, eb[k]}, {2'b0, r});
        end
        final_report();
    end
endmodule : serial_port_test
